//--- logic/pds_pkg.sv
/*
  Package for the PWM dead-band and steering output stage: register indices,
  field positions, reset values, write masks, mode codes and the shared carrier types.
  Assumes a byte-wide register port with one-cycle read latency.
*/
package pds_pkg;
  // Register indices on the plain register port
  localparam logic [1:0] PDS_DEL_IDX = 2'h0;  // Delay and restart control
  localparam logic [1:0] PDS_STR_IDX = 2'h1;  // Pulse steering control
  localparam logic [1:0] PDS_CON_IDX = 2'h2;  // Mode and output configuration
  localparam logic [1:0] PDS_STA_IDX = 2'h3;  // Status: shutdown and clock-fail flags
  // Delay register fields
  localparam int PDS_RSEN_BIT = 7;  // Auto restart enable
  // Steering register fields
  localparam int PDS_SYNC_BIT = 4;  // Steering update sync
  localparam logic [7:0] PDS_STR_RESET = 8'h01;  // Only pin A steered after reset
  localparam logic [7:0] PDS_STR_WMASK = 8'hdf;  // Bit 5 unimplemented
  // Mode register layout: [7:6] output config, [3:0] module mode
  localparam logic [1:0] PDS_MODE_PWM_HI = 2'h3;  // Upper mode bits for PWM
  localparam logic [1:0] PDS_CFG_SINGLE = 2'h0;  // Single-output configuration
  localparam logic [7:0] PDS_CON_WMASK = 8'hcf;
  // Status register fields
  localparam int PDS_ASE_BIT = 7;  // Shutdown event flag
  localparam int PDS_OSCF_BIT = 0;  // Oscillator fail flag
  localparam logic [7:0] PDS_ZERO = 8'h00;

  // Register port request
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } pds_req_t;

  // Pin bundle for the four outputs
  typedef struct packed {
    logic [3:0] out;   // Pin levels
    logic [3:0] oe_n;  // Low while the stage drives the pin
  } pds_pins_t;
endpackage : pds_pkg

//--- logic/pds_output_stage.sv
/*
  PWM output stage: dead-band delay on active-going edges, auto-shutdown with
  optional auto-restart, and steering of one waveform onto four pins.
  Assumes the period timer supplies a one-cycle period-start pulse, the duty
  generator a raw waveform, and the shutdown source a level. Sleep and the
  clock-fail switchover are signalled by the power manager.
*/
// The address-and-strobe port and the register addresses were decided locally.
// Behaviour
// - Restart enabled: flag self-clears, output resumes
// - Restart disabled: flag held until software clears
// - Seven-bit count delays active-going transition
// - Steering only in mode 11xx, config 00
// - Steer bit set routes waveform, else port
// - Waveform on any combination of pins
// - Low mode bits select steered polarity
// - Shutdown forces only enabled PWM pins
// - Pair field selects complementary assignment
// - Sync clear: steering applies immediately
// - Sync set: steering waits for period start
// - Sleep freezes state, pins hold value
// - Primary idle keeps running unchanged
// - Clock fail sets flag, switches oscillator
// - Reset restores registers, pins to input
// - Steering resets to A only, bit5 zero
// - Flag held while shutdown condition persists
// - Outputs re-enabled only at period start
`timescale 1ns/1ns
module pds_output_stage
  import pds_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST_N,
  // Register port
  input wire pds_pkg::pds_req_t REQ,
  output logic [7:0] RDATA,
  // Waveform source and timing
  input wire logic PWM_RAW,
  input wire logic PERIOD_START,
  input wire logic SHUTDOWN_COND,
  input wire logic [3:0] PORT_OUT,
  input wire logic [3:0] SHUT_LEVEL,
  input wire logic [3:0] SHUT_TRI,
  // Power management
  input wire logic SLEEP,
  input wire logic PRIMARY_IDLE,
  input wire logic CLOCK_FAIL,
  // Pins and clock selection
  output pds_pkg::pds_pins_t PINS,
  output logic USE_INTERNAL_OSC
);
  import pds_pkg::*;

  // Shutdown tracking states
  // RUN passes the steered waveform, SHUT forces the enabled pins,
  // and WAIT keeps them forced until the next period begins.
  // Holding the pins in WAIT means a restart never emits a runt
  // pulse, at the cost of up to one period of extra dead time.
  // The codes are one-hot, so any other code is illegal and
  // falls back to SHUT, the safe side.
  typedef enum logic [2:0] {
    RUN = 3'b001,   // Normal operation
    SHUT = 3'b010,  // Outputs forced
    WAIT = 3'b100   // Cleared, waiting for next period
  } pds_state_t;

  logic [7:0] del_reg;  // Restart enable and delay count
  logic [7:0] str_reg;  // Steering written by software
  logic [7:0] str_act;  // Steering currently applied
  logic str_pend;  // Synced update waiting for period
  logic [7:0] con_reg;  // Mode and output configuration
  logic ase;  // Shutdown event flag
  logic oscf;  // Oscillator fail flag
  pds_state_t state;
  logic [6:0] dead_cnt;  // Dead-band countdown
  logic raw_q;  // Raw waveform last cycle
  logic dly_wave;  // Waveform after dead band
  logic [3:0] pin_q;  // Registered pin levels
  logic [3:0] oe_q;  // Registered enables (low = drive)

  // Decode of the register port
  // Writes land on the strobe edge and there are no wait states.
  // Sleep gates every write except the oscillator fail clear,
  // so that the frozen state cannot be disturbed by software.
  // Primary idle has no effect at all: the stage keeps running.
  wire run = ~SLEEP;
  wire wr_del = REQ.wr && REQ.addr == PDS_DEL_IDX;
  wire wr_str = REQ.wr && REQ.addr == PDS_STR_IDX;
  wire wr_con = REQ.wr && REQ.addr == PDS_CON_IDX;
  wire wr_sta = REQ.wr && REQ.addr == PDS_STA_IDX;
  wire [7:0] str_wval = REQ.wdata & PDS_STR_WMASK;
  wire restart_auto_enable = del_reg[PDS_RSEN_BIT];
  wire [6:0] dead_delay_count = del_reg[6:0];
  wire steer_update_sync = str_reg[PDS_SYNC_BIT];
  wire [1:0] output_config_field = con_reg[7:6];
  wire [3:0] module_mode_field = con_reg[3:0];
  wire steer_mode = module_mode_field[3:2] == PDS_MODE_PWM_HI && output_config_field == PDS_CFG_SINGLE;
  wire [1:0] complement_pair_select = str_act[7:6];

  // Dead-band: an active-going raw edge starts the countdown
  // Only the active-going edge is delayed; the inactive-going
  // edge passes at once, which is what keeps switches from
  // conducting together. A raw pulse shorter than the count
  // is swallowed completely.
  wire rise = PWM_RAW & ~raw_q;
  wire [6:0] next_dead_cnt = rise ? dead_delay_count : (dead_cnt != 7'h00 ? dead_cnt - 7'h01 : 7'h00);
  wire next_dly_wave = PWM_RAW & (rise ? dead_delay_count == 7'h00 : (dead_cnt == 7'h00 || dead_cnt == 7'h01));

  // Which pins carry the waveform, and with what level
  // Steering is gated by the mode decode, so outside single-output
  // mode every pin falls back to its port latch.
  wire [3:0] pair_en = complement_pair_select == 2'h1 ? 4'h3 :
                       complement_pair_select == 2'h2 ? 4'h5 : 4'h9;
  wire [3:0] pwm_en = !steer_mode ? 4'h0 :
                      complement_pair_select == 2'h0 ? str_act[3:0] : pair_en;
  // Polarity: bit1 inverts A/C, bit0 inverts B/D (active-low when set)
  wire pol_ac = module_mode_field[1];
  wire pol_bd = module_mode_field[0];
  wire [3:0] pol = {pol_bd, pol_ac, pol_bd, pol_ac};
  // Complementary pair: second pin carries the inverse
  wire [3:0] comp = complement_pair_select == 2'h0 ? 4'h0 : (pair_en & 4'he);
  wire [3:0] wave4 = {4{dly_wave}} ^ comp ^ pol;
  wire forced = state != RUN;
  wire [3:0] next_pin;
  wire [3:0] next_oe;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_pin
      // Shutdown overrides only the enabled PWM pins
      assign next_pin[g] = !pwm_en[g] ? PORT_OUT[g] : (forced ? SHUT_LEVEL[g] : wave4[g]);
      assign next_oe[g] = pwm_en[g] & forced & SHUT_TRI[g];
    end
  endgenerate

  // Shutdown state machine
  // The shutdown condition is a level: the machine stays in SHUT
  // as long as it is present, whatever software writes.
  // A software clear is only honoured once the condition is gone.
  logic ase_clr_sw;
  assign ase_clr_sw = wr_sta && !REQ.wdata[PDS_ASE_BIT] && !SHUTDOWN_COND;
  pds_state_t next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      RUN: if (SHUTDOWN_COND) next_state = SHUT;
      SHUT: begin
        // Auto path clears with the condition; manual path needs software
        if (!SHUTDOWN_COND && (restart_auto_enable || ase_clr_sw)) next_state = WAIT;
      end
      WAIT: begin
        if (SHUTDOWN_COND) next_state = SHUT;
        else if (PERIOD_START) next_state = RUN;
      end
      default: next_state = SHUT;
    endcase
  end

  // Register writes; steering applies now or at period start
  // The written steering value is kept apart from the applied one,
  // so that a synced update can wait for the period boundary while
  // software still reads back what it wrote.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      del_reg <= PDS_ZERO;
      str_reg <= PDS_STR_RESET;
      str_act <= PDS_STR_RESET;
      str_pend <= 1'b0;
      con_reg <= PDS_ZERO;
    end else if (run) begin
      if (wr_del) del_reg <= REQ.wdata;
      if (wr_con) con_reg <= REQ.wdata & PDS_CON_WMASK;
      if (wr_str) begin
        str_reg <= str_wval;
        if (!str_wval[PDS_SYNC_BIT]) str_act <= str_wval;
        str_pend <= str_wval[PDS_SYNC_BIT];
      end else if (str_pend && PERIOD_START) begin
        str_act <= str_reg;
        str_pend <= 1'b0;
      end
    end
  end

  // Flags and shutdown state; events win over clears
  // The clock-fail flag is outside the sleep gate: a failing clock
  // must be recorded even while everything else is frozen.
  // The internal oscillator select is sticky until reset.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= RUN;
      ase <= 1'b0;
      oscf <= 1'b0;
      USE_INTERNAL_OSC <= 1'b0;
    end else begin
      if (CLOCK_FAIL) begin
        oscf <= 1'b1;
        USE_INTERNAL_OSC <= 1'b1;
      end else if (wr_sta && !REQ.wdata[PDS_OSCF_BIT]) oscf <= 1'b0;
      if (run) begin
        state <= next_state;
        // Software set is a firmware shutdown; writes ignored while condition holds
        if (wr_sta && REQ.wdata[PDS_ASE_BIT]) begin
          state <= SHUT;
          ase <= 1'b1;
        end else ase <= next_state == SHUT;
      end
    end
  end

  // Dead band and pin registers; sleep holds everything
  // Pins are registered so the switch drivers never see decode glitches.
  // Reset releases every pin, leaving the external pulls in charge.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      raw_q <= 1'b0;
      dead_cnt <= 7'h00;
      dly_wave <= 1'b0;
      pin_q <= 4'h0;
      oe_q <= 4'hf;
    end else if (run) begin
      raw_q <= PWM_RAW;
      dead_cnt <= next_dead_cnt;
      dly_wave <= next_dly_wave;
      pin_q <= next_pin;
      oe_q <= ~pwm_en | next_oe;
    end
  end

  // Read-back one cycle after the strobe
  // Read data is zero outside the answer cycle, so a stale value
  // can never be mistaken for a fresh one.
  wire [7:0] sta_val = {ase, 6'h00, oscf};
  wire [7:0] rd_mux = REQ.addr == PDS_DEL_IDX ? del_reg :
                      REQ.addr == PDS_STR_IDX ? str_reg :
                      REQ.addr == PDS_CON_IDX ? con_reg : sta_val;
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) RDATA <= PDS_ZERO;
    else RDATA <= REQ.rd ? rd_mux : PDS_ZERO;
  end

  assign PINS.out = pin_q;
  assign PINS.oe_n = oe_q;

  // Checks
  // Each property guards one rule of the stage; all are sampled on
  // the rising clock edge and silenced while reset is held.
  steer_gate_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    !steer_mode |=> oe_q == 4'hf) else $error("pins driven outside steering");
  bit5_zero_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    $past(REQ.rd) |-> !RDATA[5] || $past(REQ.addr) != PDS_STR_IDX) else $error("steer bit5 set");
  sync_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    str_pend && !PERIOD_START && !wr_str && run |=> $stable(str_act)) else $error("synced steer early");
  immed_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    wr_str && run && !str_wval[PDS_SYNC_BIT] |=> str_act == $past(str_wval)) else $error("steer not immediate");
  flag_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    SHUTDOWN_COND && run |=> ase) else $error("flag not set");
  manual_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    ase && !restart_auto_enable && !wr_sta && run |=> ase) else $error("flag cleared alone");
  restart_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    state == WAIT && !PERIOD_START && run |=> state != RUN) else $error("restart before period");
  sleep_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    SLEEP |=> $stable(pin_q) && $stable(dead_cnt)) else $error("state moved in sleep");
  dead_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    run && rise && dead_delay_count != 7'h00 |=> !dly_wave) else $error("no dead band");
  osc_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    CLOCK_FAIL |=> oscf && USE_INTERNAL_OSC) else $error("clock fail ignored");

  // Primary idle: pins keep following the live decode
  idle_run_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    PRIMARY_IDLE && !SLEEP |=> pin_q == $past(next_pin)) else $error("idle changed operation");

  // Auto restart clears the flag once the condition is gone
  auto_clear_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    state == SHUT && restart_auto_enable && !SHUTDOWN_COND && run && !wr_sta |=> !ase) else $error("flag not auto cleared");

  // Non-steered pins follow the port latch
  port_pin_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    run |=> ((pin_q ^ $past(PORT_OUT)) & ~$past(pwm_en)) == 4'h0) else $error("port pin wrong");

  // Steered pins are driven while running
  steer_drive_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    run && !forced |=> (oe_q & $past(pwm_en)) == 4'h0) else $error("steered pin released");

  // Steered pins carry the waveform with polarity applied
  wave_pin_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    run && !forced |=> ((pin_q ^ $past(wave4)) & $past(pwm_en)) == 4'h0) else $error("steered level wrong");

  // Shutdown forces enabled pins to their shutdown level
  shut_pin_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    run && forced |=> ((pin_q ^ $past(SHUT_LEVEL)) & $past(pwm_en)) == 4'h0) else $error("shutdown level wrong");

  // Shutdown tri-states only where asked
  shut_tri_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    run && forced |=> (oe_q & $past(pwm_en)) == ($past(SHUT_TRI) & $past(pwm_en))) else $error("shutdown drive wrong");

  // Pair modes steer exactly pin A and its partner
  pair_sel_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    steer_mode && complement_pair_select != 2'h0 |-> pwm_en[0] && $countones(pwm_en) == 2) else $error("pair wrong");

  // Unimplemented steering bit stays clear
  str_bit5_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    !str_reg[5] && !str_act[5]) else $error("steer bit5 stored");

  // Counter reloads from the delay count on an active edge
  dead_reload_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    run && rise |=> dead_cnt == $past(dead_delay_count)) else $error("dead count not reloaded");

  // A zero count passes the edge with no delay
  zero_delay_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    run && rise && dead_delay_count == 7'h00 |=> dly_wave) else $error("zero count delayed");

  // Countdown moves by one each running cycle
  count_down_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    run && !rise && dead_cnt != 7'h00 |=> dead_cnt == $past(dead_cnt) - 7'h01) else $error("dead count stalled");

  // Internal oscillator select is sticky
  osc_sticky_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    USE_INTERNAL_OSC |=> USE_INTERNAL_OSC) else $error("osc select dropped");

  // Read data stands for one cycle only
  rd_idle_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    !REQ.rd |=> RDATA == PDS_ZERO) else $error("read data lingers");
endmodule : pds_output_stage

//--- testbench/pds_switch_model.sv
/*
  Model of the external switch drivers on the four pins.
  Assumes oe_n low while the stage drives a pin, and a pull-down on each pin.
*/
`timescale 1ns/1ns
module pds_switch_model (
  // Pin drive from the stage
  input wire logic [3:0] out,
  input wire logic [3:0] oe_n,
  // Level seen by each switch driver
  output logic [3:0] level
);
  // A released pin sits at the pull-down, so the switch stays off
  assign level = ~oe_n & out;
endmodule : pds_switch_model

//--- testbench/tb.sv
/*
  Self-checking bench for the PWM output stage.
  Assumes a 10 MHz clock and the one-cycle register port of the stage.
*/
`timescale 1ns/1ns
module tb;
  import pds_pkg::*;
  logic clk, rst_n, raw, per, sd, slp, idle, cf, osc;
  logic [3:0] port, slv, stri, lvl;
  logic [7:0] rdata;
  pds_req_t req;
  pds_pins_t pins;
  int fails, compares, d0, d;
  // Stage under test and the switch drivers behind its pins
  pds_output_stage i_dut(.MCLK(clk), .RST_N(rst_n), .REQ(req), .RDATA(rdata), .PWM_RAW(raw),
    .PERIOD_START(per), .SHUTDOWN_COND(sd), .PORT_OUT(port), .SHUT_LEVEL(slv), .SHUT_TRI(stri),
    .SLEEP(slp), .PRIMARY_IDLE(idle), .CLOCK_FAIL(cf), .PINS(pins), .USE_INTERNAL_OSC(osc));
  pds_switch_model i_sw(.out(pins.out), .oe_n(pins.oe_n), .level(lvl));
  // Clock at 100 ns
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic ck(input string n, input logic [7:0] s, input logic [7:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : ck
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk) req <= {a, v, 2'b10};
    @(posedge clk) req <= '0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk) req <= {a, 8'h00, 2'b01};
    @(posedge clk) req <= '0;
    #1 ck("rdata", rdata, e);
  endtask : rd
  // Pins settle within three edges of their cause
  task automatic pc(input logic [3:0] e);
    repeat (3) @(posedge clk);
    #1 ck("pins", {4'h0, pins.out}, {4'h0, e});
  endtask : pc
  task automatic pulse;
    @(posedge clk) per <= 1'b1;
    @(posedge clk) per <= 1'b0;
  endtask : pulse
  task automatic t_reset;
    rd(PDS_DEL_IDX, 8'h00);
    rd(PDS_STR_IDX, 8'h01);
    rd(PDS_CON_IDX, 8'h00);
    rd(PDS_STA_IDX, 8'h00);
    ck("oe_n", {4'h0, pins.oe_n}, 8'h0f);
    wr(PDS_STR_IDX, 8'h2f);
    rd(PDS_STR_IDX, 8'h0f);
  endtask : t_reset
  // Every nonzero pin mask under every polarity, steering applied at once
  task automatic t_steer;
    logic [3:0] m, inv;
    for (int i = 0; i < 4; i++) begin
      wr(PDS_CON_IDX, 8'h0c + 8'(i));
      inv = {i[0], i[1], i[0], i[1]};
      for (int k = 1; k < 16; k++) begin
        m = 4'(k);
        wr(PDS_STR_IDX, {4'h0, m});
        pc((m & ~inv) | (~m & port));
      end
    end
    wr(PDS_CON_IDX, 8'h08);
    pc(port);
    wr(PDS_CON_IDX, 8'h4c);
    pc(port);
    wr(PDS_CON_IDX, 8'h0c);
    wr(PDS_STR_IDX, 8'h01);
    wr(PDS_STR_IDX, 8'h14);
    pc(4'h1 | port);
    pulse;
    pc(4'h4 | port);
    for (int k = 1; k < 4; k++) begin
      wr(PDS_STR_IDX, {2'(k), 6'h01});
      pc((4'h1 | port) & ~(4'h1 << k));
      ck("pair", {6'h0, pins.out[0], pins.out[k]}, 8'h02);
    end
    wr(PDS_STR_IDX, 8'h01);
  endtask : t_steer
  // Shutdown with manual or automatic restart
  task automatic t_shut(input logic rsen);
    raw <= 1'b0;
    stri <= {4{rsen}};
    wr(PDS_DEL_IDX, {rsen, 7'h00});
    sd <= 1'b1;
    pc(port | 4'h1);
    ck("level a", {7'h0, lvl[0]}, {7'h0, ~rsen});
    rd(PDS_STA_IDX, 8'h80);
    wr(PDS_STA_IDX, 8'h00);
    rd(PDS_STA_IDX, 8'h80);
    sd <= 1'b0;
    repeat (3) @(posedge clk);
    rd(PDS_STA_IDX, rsen ? 8'h00 : 8'h80);
    wr(PDS_STA_IDX, 8'h00);
    rd(PDS_STA_IDX, 8'h00);
    ck("held", {7'h0, pins.oe_n[0] | pins.out[0]}, 8'h01);
    pulse;
    pc(port & 4'he);
  endtask : t_shut
  task automatic meas(input logic [6:0] n, output int c);
    wr(PDS_DEL_IDX, {1'b0, n});
    raw <= 1'b0;
    repeat (3) @(posedge clk);
    raw <= 1'b1;
    c = 0;
    do begin
      @(posedge clk);
      #1 c++;
    end while (pins.out[0] !== 1'b1 && c < 300);
  endtask : meas
  task automatic t_dead;
    meas(7'h00, d0);
    meas(7'h05, d);
    ck("delay", 8'(d - d0), 8'h05);
    meas(7'h7f, d);
    ck("delay", 8'(d - d0), 8'h7f);
  endtask : t_dead
  // Sleep freeze, clock fail, primary idle, reset again
  task automatic t_power;
    pc(port | 4'h1);
    slp <= 1'b1;
    raw <= 1'b0;
    wr(PDS_STR_IDX, 8'h0f);
    @(posedge clk) cf <= 1'b1;
    @(posedge clk) cf <= 1'b0;
    pc(port | 4'h1);
    slp <= 1'b0;
    rd(PDS_STR_IDX, 8'h01);
    rd(PDS_STA_IDX, 8'h01);
    ck("osc", {7'h0, osc}, 8'h01);
    idle <= 1'b1;
    pc(port & 4'he);
    @(posedge clk) rst_n <= 1'b0;
    @(posedge clk) rst_n <= 1'b1;
    rd(PDS_STR_IDX, 8'h01);
    ck("osc", {7'h0, osc}, 8'h00);
    ck("oe_n", {4'h0, pins.oe_n}, 8'h0f);
  endtask : t_power
  task automatic results;
    if (fails == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  // Watchdog well past the expected run of a few hundred cycles
  initial begin
    #3000000;
    fails++;
    results;
  end
  initial begin
    {rst_n, raw, per, sd, slp, idle, cf} = 7'b0100000;
    req = '0;
    port = 4'ha;
    slv = 4'hf;
    stri = 4'h0;
    fails = 0;
    compares = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_steer;
    t_shut(1'b0);
    t_shut(1'b1);
    t_dead;
    t_power;
    results;
  end
endmodule : tb
